// file: hw/pshp_regs.vh
// pshp_regs.vh: register offsets, field positions, reset values and codes for the system header parser
// assumes a 32-bit apb slave with word-aligned registers
`ifndef PSHP_REGS_VH
`define PSHP_REGS_VH
`define PSHP_OFF_CTRL       12'h000
`define PSHP_OFF_STATUS     12'h004
`define PSHP_OFF_RATE       12'h008
`define PSHP_OFF_BOUNDS     12'h00C
`define PSHP_OFF_AUD_LIMIT  12'h010
`define PSHP_OFF_VID_LIMIT  12'h014
`define PSHP_OFF_LAST_ENTRY 12'h018
`define PSHP_OFF_COUNTS     12'h01C
`define PSHP_OFF_CAPACITY   12'h020
`define PSHP_CTRL_RESET     32'h0000_0001
`define PSHP_CAPACITY_RESET 22'h3F_FFFF
`define PSHP_START_CODE     32'h0000_01BB
`define PSHP_ID_ALL_AUDIO   8'hB8
`define PSHP_ID_ALL_VIDEO   8'hB9
`define PSHP_ID_MIN_STREAM  8'hBC
`define PSHP_ID_MAP         8'hBC
`define PSHP_AUDIO_MAX      6'd32
`define PSHP_VIDEO_MAX      5'd16
`define PSHP_SHIFT_SMALL    5'd7
`define PSHP_SHIFT_LARGE    5'd10
`define PSHP_ST_CTRL_EN     0
`define PSHP_ST_BUSY        0
`define PSHP_ST_DONE        1
`define PSHP_ST_ERR_MARK    2
`define PSHP_ST_ERR_RANGE   3
`define PSHP_ST_ERR_OVER    4
`define PSHP_ST_FIXED       5
`define PSHP_ST_CONSTR      6
`define PSHP_ST_ALOCK       7
`define PSHP_ST_VLOCK       8
`define PSHP_ST_PRR         9
`define PSHP_ST_PRR_VALID   10
`define PSHP_ST_CAP_OK      11
`define PSHP_ST_ERR_ID      12
`define PSHP_ST_MAP_SEEN    13
`endif

// file: hw/pshp_apb_slave.v
// pshp_apb_slave.v: zero-wait apb slave decode for the system header parser registers
// assumes apb3 signalling on SYS_CLK; read data mux comes in flattened from the parser
`timescale 1ns/1ps
`default_nettype none
`include "pshp_regs.vh"
module pshp_apb_slave (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // apb
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // register side
  input  wire [287:0] rd_words,
  output reg          wr_ctrl,
  output reg          wr_status,
  output reg          wr_capacity,
  output reg  [31:0]  wr_data
);
  wire       setup_q = psel & ~penable;
  wire [9:0] index   = paddr[11:2];
  wire       mapped  = (index < 10'd9) && (paddr[1:0] == 2'b00);

  // one-cycle answer: pready rises in the access phase, writes commit there
  always @(posedge clk) begin
    if (rst) begin
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      wr_ctrl     <= 1'b0;
      wr_status   <= 1'b0;
      wr_capacity <= 1'b0;
      wr_data     <= 32'h0000_0000;
    end else begin
      pready      <= setup_q;
      pslverr     <= setup_q & ~mapped;
      wr_ctrl     <= setup_q & pwrite & (paddr == `PSHP_OFF_CTRL);
      wr_status   <= setup_q & pwrite & (paddr == `PSHP_OFF_STATUS);
      wr_capacity <= setup_q & pwrite & (paddr == `PSHP_OFF_CAPACITY);
      wr_data     <= pwdata;
      if (setup_q && !pwrite && mapped) begin
        prdata <= rd_words[index[3:0]*32 +: 32];
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end
endmodule // pshp_apb_slave
`default_nettype wire

// file: hw/pshp_parser.v
// pshp_parser.v: system header parser top, byte stream in, header fields out and over apb
// assumes one byte per SYS_CLK when BYTE_VALID is high, from logic on the same clock
//
// How it works
// R1: header starts only after byte-aligned pattern 0x000001BB.
// R2: length counts bytes after it; unknown trailing bytes skipped to the end.
// R3: peak rate stored and compared against software capacity.
// R4: audio bound must be 0..32, checked by parser.
// R5: fixed-rate bit one means constant bitrate, zero variable.
// R6: fixed-rate clock references follow a linear law; source duty.
// R7: constrained bit one means constrained-parameter limits hold.
// R8: audio lock only with exact clock to sample ratio; source duty.
// R9: video lock only with exact tabulated picture ratio; source duty.
// R10: video bound must be 0..16, checked by parser.
// R11: active decode definitions; decoder control counts them.
// R12: restriction bit only meaningful when constrained bit set.
// R13: reserved byte sent as all ones; source duty.
// R14: identifier B8 sets limit for all audio streams.
// R15: identifier B9 sets limit for all video streams.
// R16: other identifiers must be at least BC, passed out per entry.
// R17: each stream gets its bound once per header; source duty.
// R18: scale bit zero for audio, one for video; source duty.
// R19: bound times 128 or 1024 by scale bit gives bytes.
// R20: identifier BC packet flagged as stream map, passed unaltered.
// R21: bytes after headers are left to the packet parser.
// R22: loop runs while next bit is one; 24-bit entries.
// R23: every marker bit must be one.
// R24: fields taken msb first in documented order.
// R25: error flag on zero marker, bad bound, or entry overrun.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pshp_regs.vh"
module pshp_parser (
  // clock and reset
  input  wire        SYS_CLK,
  input  wire        SRST,
  // byte stream in
  input  wire [7:0]  BYTE_DATA,
  input  wire        BYTE_VALID,
  // byte stream out, unaltered
  output reg  [7:0]  PASS_DATA,
  output reg         PASS_VALID,
  output reg         PASS_IN_HEADER,
  output reg         PASS_IS_MAP_START,
  // per-entry and per-header results
  output reg         ENTRY_VALID,
  output reg  [7:0]  ENTRY_CHANNEL_TAG,
  output reg  [23:0] ENTRY_BYTE_LIMIT,
  output reg         HEADER_DONE,
  output reg         HEADER_ERROR,
  // apb
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR
);
  // one-hot parse states; any other code falls back to hunting
  localparam [7:0] S_HUNT  = 8'b0000_0001;
  localparam [7:0] S_LEN   = 8'b0000_0010;
  localparam [7:0] S_FIX   = 8'b0000_0100;
  localparam [7:0] S_LOOP  = 8'b0000_1000;
  localparam [7:0] S_ENTRY = 8'b0001_0000;
  localparam [7:0] S_SKIP  = 8'b0010_0000;

  reg  [7:0]  state_q;
  reg  [31:0] shift_q;
  reg  [15:0] remain_q;
  reg  [3:0]  fix_idx_q;
  reg  [1:0]  ent_idx_q;
  reg  [63:0] fix_q;
  reg  [15:0] ent_q;
  reg         enable_q;
  reg  [21:0] capacity_q;
  reg         busy_q, done_q, err_mark_q, err_range_q, err_over_q, err_id_q, map_seen_q;
  reg  [21:0] rate_q;
  reg  [5:0]  aud_bound_q;
  reg  [4:0]  vid_bound_q;
  reg         fixed_q, constr_q, alock_q, vlock_q, prr_q;
  reg  [23:0] aud_limit_q, vid_limit_q;
  reg  [31:0] last_entry_q;
  reg  [7:0]  entry_count_q;
  reg  [7:0]  header_count_q;
  reg  [23:0] pkt_shift_q;

  wire        wr_ctrl, wr_status, wr_capacity;
  wire [31:0] wr_data;
  wire [31:0] window = {shift_q[23:0], BYTE_DATA};
  wire        last_byte = (remain_q == 16'd1);
  // fixed part: rate(marker..) 6 bytes after length
  wire [47:0] fixed_bits = {fix_q[39:0], BYTE_DATA};
  wire [23:0] entry_bits = {ent_q, BYTE_DATA};
  wire [7:0]  ent_tag    = entry_bits[23:16];
  wire        ent_scale  = entry_bits[13];
  wire [12:0] ent_bound  = entry_bits[12:0];
  // R19
  wire [23:0] ent_bytes  = ent_scale ? ({11'h000, ent_bound} << `PSHP_SHIFT_LARGE)
                                     : ({11'h000, ent_bound} << `PSHP_SHIFT_SMALL);

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      state_q <= S_HUNT;
      shift_q <= 32'h0000_0000;
      remain_q <= 16'h0000;
      fix_idx_q <= 4'h0;
      ent_idx_q <= 2'b00;
      fix_q <= 64'h0000_0000_0000_0000;
      ent_q <= 16'h0000;
      enable_q <= 1'b1;
      capacity_q <= `PSHP_CAPACITY_RESET;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      err_mark_q <= 1'b0;
      err_range_q <= 1'b0;
      err_over_q <= 1'b0;
      err_id_q <= 1'b0;
      map_seen_q <= 1'b0;
      rate_q <= 22'h00_0000;
      aud_bound_q <= 6'h00;
      vid_bound_q <= 5'h00;
      fixed_q <= 1'b0;
      constr_q <= 1'b0;
      alock_q <= 1'b0;
      vlock_q <= 1'b0;
      prr_q <= 1'b0;
      aud_limit_q <= 24'h00_0000;
      vid_limit_q <= 24'h00_0000;
      last_entry_q <= 32'h0000_0000;
      entry_count_q <= 8'h00;
      header_count_q <= 8'h00;
      pkt_shift_q <= 24'h00_0000;
      PASS_DATA <= 8'h00;
      PASS_VALID <= 1'b0;
      PASS_IN_HEADER <= 1'b0;
      PASS_IS_MAP_START <= 1'b0;
      ENTRY_VALID <= 1'b0;
      ENTRY_CHANNEL_TAG <= 8'h00;
      ENTRY_BYTE_LIMIT <= 24'h00_0000;
      HEADER_DONE <= 1'b0;
      HEADER_ERROR <= 1'b0;
    end else begin
      ENTRY_VALID <= 1'b0;
      HEADER_DONE <= 1'b0;
      HEADER_ERROR <= 1'b0;
      PASS_VALID <= BYTE_VALID;
      PASS_DATA <= BYTE_DATA;
      PASS_IS_MAP_START <= 1'b0;
      // flag holds through gaps inside a header and drops once the length runs out
      PASS_IN_HEADER <= (state_q != S_HUNT);
      if (wr_ctrl) begin
        enable_q <= wr_data[`PSHP_ST_CTRL_EN];
      end
      if (wr_capacity) begin
        capacity_q <= wr_data[21:0];
      end
      // sticky flags: clear by writing one, a same-cycle set wins below
      if (wr_status) begin
        if (wr_data[`PSHP_ST_DONE])      done_q <= 1'b0;
        if (wr_data[`PSHP_ST_ERR_MARK])  err_mark_q <= 1'b0;
        if (wr_data[`PSHP_ST_ERR_RANGE]) err_range_q <= 1'b0;
        if (wr_data[`PSHP_ST_ERR_OVER])  err_over_q <= 1'b0;
        if (wr_data[`PSHP_ST_ERR_ID])    err_id_q <= 1'b0;
        if (wr_data[`PSHP_ST_MAP_SEEN])  map_seen_q <= 1'b0;
      end
      if (BYTE_VALID) begin
        shift_q <= window;
        // packets after the headers go through untouched to the packet parser
        pkt_shift_q <= {pkt_shift_q[15:0], BYTE_DATA};                   // R21
        if (state_q == S_HUNT && {pkt_shift_q, BYTE_DATA} == {24'h00_0001, `PSHP_ID_MAP}) begin
          map_seen_q <= 1'b1;                                            // R20
          PASS_IS_MAP_START <= 1'b1;                                     // R20
        end
        PASS_IN_HEADER <= (state_q != S_HUNT) || (enable_q && window == `PSHP_START_CODE);
        case (state_q)
          S_HUNT: begin
            if (enable_q && window == `PSHP_START_CODE) begin            // R1
              state_q <= S_LEN;
              fix_idx_q <= 4'h0;
              busy_q <= 1'b1;
              entry_count_q <= 8'h00;
            end
          end

          S_LEN: begin
            fix_idx_q <= fix_idx_q + 4'h1;
            if (fix_idx_q == 4'h1) begin
              remain_q <= {shift_q[7:0], BYTE_DATA};                     // R2
              fix_idx_q <= 4'h0;
              // too short to hold the fixed fields, so nothing after it is trusted
              if ({shift_q[7:0], BYTE_DATA} < 16'd6) begin
                err_over_q <= 1'b1;                                      // R25
                HEADER_ERROR <= 1'b1;
                state_q <= ({shift_q[7:0], BYTE_DATA} == 16'd0) ? S_HUNT : S_SKIP;
                busy_q <= ({shift_q[7:0], BYTE_DATA} != 16'd0);
              end else begin
                state_q <= S_FIX;
              end
            end
          end

          S_FIX: begin
            remain_q <= remain_q - 16'd1;
            fix_q <= {fix_q[55:0], BYTE_DATA};                            // R24
            fix_idx_q <= fix_idx_q + 4'h1;
            if (fix_idx_q == 4'h5) begin
              rate_q <= fixed_bits[46:25];                               // R3
              aud_bound_q <= fixed_bits[23:18];                          // R11
              fixed_q <= fixed_bits[17];                                 // R5
              constr_q <= fixed_bits[16];                                // R7
              alock_q <= fixed_bits[15];
              vlock_q <= fixed_bits[14];
              vid_bound_q <= fixed_bits[12:8];
              // restriction bit kept only when the constrained bit is set
              prr_q <= fixed_bits[16] & fixed_bits[7];                   // R12
              if (!fixed_bits[47] || !fixed_bits[24] || !fixed_bits[13]) begin
                err_mark_q <= 1'b1;                                      // R23
                HEADER_ERROR <= 1'b1;                                    // R25
              end
              if (fixed_bits[23:18] > `PSHP_AUDIO_MAX || fixed_bits[12:8] > `PSHP_VIDEO_MAX) begin
                err_range_q <= 1'b1;                                     // R4 R10
                HEADER_ERROR <= 1'b1;                                    // R25
              end
              state_q <= last_byte ? S_HUNT : S_LOOP;
              if (last_byte) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
                HEADER_DONE <= 1'b1;
                header_count_q <= header_count_q + 8'h01;
              end
            end
          end

          S_LOOP: begin
            remain_q <= remain_q - 16'd1;
            if (BYTE_DATA[7]) begin                                      // R22
              ent_q <= {8'h00, BYTE_DATA};
              ent_idx_q <= 2'b01;
              state_q <= S_ENTRY;
              // entry would run past the declared length
              if (remain_q < 16'd3) begin
                err_over_q <= 1'b1;                                      // R25
                HEADER_ERROR <= 1'b1;
                state_q <= last_byte ? S_HUNT : S_SKIP;
              end
            end else begin
              // unknown extension bytes: walk off the rest of the length
              state_q <= last_byte ? S_HUNT : S_SKIP;                    // R2
            end
            if (last_byte) begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              HEADER_DONE <= 1'b1;
              header_count_q <= header_count_q + 8'h01;
            end
          end

          S_ENTRY: begin
            remain_q <= remain_q - 16'd1;
            ent_q <= {ent_q[7:0], BYTE_DATA};
            ent_idx_q <= ent_idx_q + 2'b01;
            if (ent_idx_q == 2'b10) begin
              ENTRY_VALID <= 1'b1;                                       // R16
              ENTRY_CHANNEL_TAG <= ent_tag;
              ENTRY_BYTE_LIMIT <= ent_bytes;                             // R19
              last_entry_q <= {ent_tag, ent_bytes};
              entry_count_q <= entry_count_q + 8'h01;
              if (ent_tag == `PSHP_ID_ALL_AUDIO) aud_limit_q <= ent_bytes;   // R14
              if (ent_tag == `PSHP_ID_ALL_VIDEO) vid_limit_q <= ent_bytes;   // R15
              if (ent_tag != `PSHP_ID_ALL_AUDIO && ent_tag != `PSHP_ID_ALL_VIDEO &&
                  ent_tag < `PSHP_ID_MIN_STREAM) begin
                err_id_q <= 1'b1;                                        // R16
                HEADER_ERROR <= 1'b1;
              end
              if (entry_bits[15:14] != 2'b11) begin
                err_mark_q <= 1'b1;                                      // R23
                HEADER_ERROR <= 1'b1;                                    // R25
              end
              state_q <= last_byte ? S_HUNT : S_LOOP;
              if (last_byte) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
                HEADER_DONE <= 1'b1;
                header_count_q <= header_count_q + 8'h01;
              end
            end
          end

          S_SKIP: begin
            remain_q <= remain_q - 16'd1;
            if (last_byte) begin
              state_q <= S_HUNT;                                         // R2
              busy_q <= 1'b0;
              done_q <= 1'b1;
              HEADER_DONE <= 1'b1;
              header_count_q <= header_count_q + 8'h01;
            end
          end

          default: begin
            state_q <= S_HUNT;
          end
        endcase
      end
    end
  end

  // read words, index order matches the offsets
  wire [31:0] status_word = {18'h0_0000, map_seen_q, err_id_q, (rate_q <= capacity_q), constr_q,  // R3
                             prr_q, vlock_q, alock_q, constr_q, fixed_q, err_over_q, err_range_q,
                             err_mark_q, done_q, busy_q};
  wire [287:0] rd_words = {
    {10'h000, capacity_q},
    {16'h0000, header_count_q, entry_count_q},
    last_entry_q,
    {8'h00, vid_limit_q},
    {8'h00, aud_limit_q},
    {21'h00_0000, vid_bound_q, aud_bound_q},
    {10'h000, rate_q},
    status_word,
    {31'h0000_0000, enable_q}
  };

  pshp_apb_slave u_apb (
    .clk         (SYS_CLK),
    .rst         (SRST),
    .psel        (PSEL),
    .penable     (PENABLE),
    .pwrite      (PWRITE),
    .paddr       (PADDR),
    .pwdata      (PWDATA),
    .prdata      (PRDATA),
    .pready      (PREADY),
    .pslverr     (PSLVERR),
    .rd_words    (rd_words),
    .wr_ctrl     (wr_ctrl),
    .wr_status   (wr_status),
    .wr_capacity (wr_capacity),
    .wr_data     (wr_data)
  );
endmodule // pshp_parser
`default_nettype wire

// file: dv/pshp_parser_sva.sv
// pshp_parser_sva.sv: port-level checker for the system header parser, bound to pshp_parser
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module pshp_parser_sva (
  // clock and reset
  input wire logic        SYS_CLK,
  input wire logic        SRST,
  // byte stream
  input wire logic [7:0]  BYTE_DATA,
  input wire logic        BYTE_VALID,
  input wire logic [7:0]  PASS_DATA,
  input wire logic        PASS_VALID,
  input wire logic        PASS_IN_HEADER,
  input wire logic        PASS_IS_MAP_START,
  // results
  input wire logic        ENTRY_VALID,
  input wire logic [7:0]  ENTRY_CHANNEL_TAG,
  input wire logic [23:0] ENTRY_BYTE_LIMIT,
  input wire logic        HEADER_DONE,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PREADY
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  property p_pass; BYTE_VALID |=> PASS_VALID && PASS_DATA == $past(BYTE_DATA); endproperty
  a_pass: assert property (p_pass) else $error("byte not passed unaltered");
  property p_idle; !BYTE_VALID |=> !PASS_VALID; endproperty
  a_idle: assert property (p_idle) else $error("pass valid without input byte");
  property p_map; PASS_IS_MAP_START |-> PASS_VALID && PASS_DATA == 8'hBC && !PASS_IN_HEADER; endproperty
  a_map: assert property (p_map) else $error("map start on wrong byte");
  property p_start; $rose(PASS_IN_HEADER) |-> PASS_DATA == 8'hBB; endproperty
  a_start: assert property (p_start) else $error("header began without start pattern");
  property p_scale; ENTRY_VALID |-> ENTRY_BYTE_LIMIT[6:0] == 7'h00 &&
    (ENTRY_BYTE_LIMIT[9:7] == 3'h0 || ENTRY_BYTE_LIMIT[23:20] == 4'h0); endproperty
  a_scale: assert property (p_scale) else $error("byte limit not a unit multiple");
  property p_hold; !ENTRY_VALID |-> $stable(ENTRY_CHANNEL_TAG) && $stable(ENTRY_BYTE_LIMIT); endproperty
  a_hold: assert property (p_hold) else $error("entry result changed between entries");
  property p_done; HEADER_DONE |=> !PASS_IN_HEADER; endproperty
  a_done: assert property (p_done) else $error("header continues past its length");
  property p_entry; ENTRY_VALID |-> PASS_IN_HEADER && PASS_VALID; endproperty
  a_entry: assert property (p_entry) else $error("entry outside header bytes");
  property p_ready; PSEL && !PENABLE |=> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("apb access not answered");
  c_entry: cover property (ENTRY_VALID);
  c_done: cover property (HEADER_DONE);
  c_map: cover property (PASS_IS_MAP_START);
endmodule // pshp_parser_sva
bind pshp_parser pshp_parser_sva i_pshp_parser_sva (
  .SYS_CLK(SYS_CLK), .SRST(SRST), .BYTE_DATA(BYTE_DATA), .BYTE_VALID(BYTE_VALID),
  .PASS_DATA(PASS_DATA), .PASS_VALID(PASS_VALID), .PASS_IN_HEADER(PASS_IN_HEADER),
  .PASS_IS_MAP_START(PASS_IS_MAP_START), .ENTRY_VALID(ENTRY_VALID), .ENTRY_CHANNEL_TAG(ENTRY_CHANNEL_TAG),
  .ENTRY_BYTE_LIMIT(ENTRY_BYTE_LIMIT), .HEADER_DONE(HEADER_DONE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY));
`default_nettype wire

// file: dv/pshp_src_model.sv
// pshp_src_model.sv: upstream byte source feeding the parser one byte per valid cycle
// assumes the bench queues whole byte sequences through put; slow inserts a gap per byte
`timescale 1ns/1ps
`default_nettype none
module pshp_src_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // pacing
  input  wire logic       slow,
  // byte stream
  output var  logic [7:0] data = 8'h00,
  output var  logic       valid = 1'b0
);
  logic [7:0] q[$];
  logic       gap_q = 1'b0;
  task automatic put(input logic [7:0] b);
    q.push_back(b);
  endtask
  // idle data toggles so a stale byte never looks valid
  always @(posedge clk) begin
    if (rst) begin
      valid <= 1'b0;
      gap_q <= 1'b0;
    end else if (q.size() != 0 && !(slow && !gap_q)) begin
      data  <= q.pop_front();
      valid <= 1'b1;
      gap_q <= 1'b0;
    end else begin
      data  <= ~data;
      valid <= 1'b0;
      gap_q <= 1'b1;
    end
  end
endmodule // pshp_src_model
`default_nettype wire

// file: dv/pshp_parser_tb.sv
// pshp_parser_tb.sv: self-checking bench for the system header parser
// assumes the byte source model beside it and the register offsets header
`timescale 1ns/1ps
`default_nettype none
`include "pshp_regs.vh"
module pshp_parser_tb;
  typedef struct packed {
    logic [21:0] r;
    logic [5:0]  a;
    logic [3:0]  f;
    logic [4:0]  v;
    logic        p;
    logic [7:0]  id;
    logic        s;
    logic [12:0] bd;
    logic [15:0] len;
    logic        sl;
    logic        m;
    logic [23:0] lim;
  } pshp_row_t;
  logic        SYS_CLK = 1'b0;
  logic        SRST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic        slow = 1'b0;
  wire  [7:0]  BYTE_DATA, PASS_DATA, ENTRY_CHANNEL_TAG;
  wire  [23:0] ENTRY_BYTE_LIMIT;
  wire  [31:0] PRDATA;
  wire         BYTE_VALID, PASS_VALID, PASS_IN_HEADER, PASS_IS_MAP_START;
  wire         ENTRY_VALID, HEADER_DONE, HEADER_ERROR, PREADY, PSLVERR;
  logic [31:0] rdv;
  logic        serr;
  logic [7:0]  l_tag;
  logic [23:0] l_lim;
  int          n_ent, n_done, n_err, n_map, err_count, check_count;
  pshp_row_t   rows [4] = '{
    '{22'h3F_FFFF, 6'h20, 4'h8, 5'h10, 1'b1, 8'hB8, 1'b0, 13'h1FFF, 16'h0009, 1'b0, 1'b1, 24'h0F_FF80},
    '{22'h00_0001, 6'h00, 4'h7, 5'h00, 1'b1, 8'hB9, 1'b1, 13'h0001, 16'h0009, 1'b1, 1'b1, 24'h00_0400},
    '{22'h2A_5555, 6'h05, 4'h4, 5'h03, 1'b0, 8'hBC, 1'b0, 13'h0ABC, 16'h000B, 1'b0, 1'b1, 24'h05_5E00},
    '{22'h15_AAAA, 6'h01, 4'hF, 5'h02, 1'b1, 8'hFF, 1'b1, 13'h1000, 16'h000A, 1'b1, 1'b1, 24'h40_0000}};
  pshp_parser i_pshp_parser (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .BYTE_DATA(BYTE_DATA), .BYTE_VALID(BYTE_VALID),
    .PASS_DATA(PASS_DATA), .PASS_VALID(PASS_VALID), .PASS_IN_HEADER(PASS_IN_HEADER),
    .PASS_IS_MAP_START(PASS_IS_MAP_START), .ENTRY_VALID(ENTRY_VALID), .ENTRY_CHANNEL_TAG(ENTRY_CHANNEL_TAG),
    .ENTRY_BYTE_LIMIT(ENTRY_BYTE_LIMIT), .HEADER_DONE(HEADER_DONE), .HEADER_ERROR(HEADER_ERROR),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
  pshp_src_model i_pshp_src_model (.clk(SYS_CLK), .rst(SRST), .slow(slow), .data(BYTE_DATA), .valid(BYTE_VALID));
  always #25 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    if (ENTRY_VALID === 1'b1) begin
      n_ent++;
      l_tag = ENTRY_CHANNEL_TAG;
      l_lim = ENTRY_BYTE_LIMIT;
    end
    if (HEADER_DONE === 1'b1) n_done++;
    if (HEADER_ERROR === 1'b1) n_err++;
    if (PASS_IS_MAP_START === 1'b1) n_map++;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin @(posedge SYS_CLK); end while (PREADY !== 1'b1);
    rdv = PRDATA;
    serr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b[$], input logic sl);
    n_ent = 0;
    n_done = 0;
    n_err = 0;
    n_map = 0;
    @(posedge SYS_CLK) slow <= sl;
    @(negedge SYS_CLK);
    foreach (b[k]) i_pshp_src_model.put(b[k]);
    while (i_pshp_src_model.q.size() != 0) @(posedge SYS_CLK);
    repeat (4) @(posedge SYS_CLK);
  endtask
  task automatic hdr(input pshp_row_t w);
    logic [7:0] b[$];
    b = '{8'h00, 8'h00, 8'h01, 8'hBB, w.len[15:8], w.len[7:0], {w.m, w.r[21:15]}, w.r[14:7],
          {w.r[6:0], 1'b1}, {w.a, w.f[3:2]}, {w.f[1:0], 1'b1, w.v}, {w.p, 7'h7F},
          w.id, {2'b11, w.s, w.bd[12:8]}, w.bd[7:0]};
    // trailing bytes have msb clear so the loop ends and they are skipped
    for (int k = 9; k < w.len; k++) b.push_back(8'h5A);
    send(b, w.sl);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge SYS_CLK);
    $display("watchdog expired");
    err_count++;
    tally_and_finish;
  end
  initial begin
    pshp_row_t e;
    int bt;
    repeat (8) @(posedge SYS_CLK);
    SRST <= 1'b0;
    apb(1'b1, `PSHP_OFF_CAPACITY, 32'h0020_0000);
    for (int i = 0; i < 4; i++) begin
      e = rows[i];
      apb(1'b1, `PSHP_OFF_STATUS, 32'h0000_301E);
      hdr(e);
      chk("entries", n_ent, 1);
      chk("done", n_done, 1);
      chk("tag", l_tag, e.id);
      chk("limit", l_lim, e.lim);
      apb(1'b0, `PSHP_OFF_STATUS, 32'h0000_0000);
      chk("status", rdv & 32'h0000_3FFF, {20'h0_0000, e.r <= 22'h20_0000, e.f[2], e.p & e.f[2], e.f[0],
          e.f[1], e.f[2], e.f[3], 3'b000, 2'b10});
      apb(1'b0, `PSHP_OFF_RATE, 32'h0000_0000);
      chk("rate", rdv, e.r);
      apb(1'b0, `PSHP_OFF_BOUNDS, 32'h0000_0000);
      chk("bounds", rdv, {e.v, e.a});
      apb(1'b0, `PSHP_OFF_LAST_ENTRY, 32'h0000_0000);
      chk("last entry", rdv, {e.id, e.lim});
      apb(1'b0, e.id == 8'hB9 ? `PSHP_OFF_VID_LIMIT : `PSHP_OFF_AUD_LIMIT, 32'h0000_0000);
      if (e.id == 8'hB8 || e.id == 8'hB9) chk("group limit", rdv, e.lim);
      $display("row %0d done", i);
    end
    for (int k = 0; k < 5; k++) begin
      e = rows[2];
      bt = 3;
      case (k)
        0: e.m = 1'b0;
        1: e.a = 6'h21;
        2: e.v = 5'h11;
        3: e.len = 16'h0007;
        default: e.id = 8'hBA;
      endcase
      if (k == 0) bt = 2;
      if (k == 3) bt = 4;
      if (k == 4) bt = 12;
      apb(1'b1, `PSHP_OFF_STATUS, 32'h0000_301E);
      hdr(e);
      apb(1'b0, `PSHP_OFF_STATUS, 32'h0000_0000);
      chk("error pulse", n_err != 0, 1);
      chk("error bit", rdv[bt], 1);
    end
    $display("error cases done");
    apb(1'b1, `PSHP_OFF_CTRL, 32'h0000_0000);
    hdr(rows[0]);
    chk("disabled done", n_done, 0);
    chk("disabled entries", n_ent, 0);
    apb(1'b1, `PSHP_OFF_CTRL, 32'h0000_0001);
    send('{8'h00, 8'h00, 8'h01, 8'hBC, 8'h55}, 1'b0);
    chk("map pulse", n_map, 1);
    apb(1'b0, `PSHP_OFF_STATUS, 32'h0000_0000);
    chk("map bit", rdv[13], 1);
    apb(1'b1, `PSHP_OFF_STATUS, 32'h0000_2000);
    apb(1'b0, `PSHP_OFF_STATUS, 32'h0000_0000);
    chk("map clear", rdv[13], 0);
    $display("enable and map done");
    @(posedge SYS_CLK) SRST <= 1'b1;
    repeat (8) @(posedge SYS_CLK);
    SRST <= 1'b0;
    apb(1'b0, `PSHP_OFF_CTRL, 32'h0000_0000);
    chk("ctrl reset", rdv, 32'h0000_0001);
    apb(1'b0, `PSHP_OFF_CAPACITY, 32'h0000_0000);
    chk("capacity reset", rdv, 32'h003F_FFFF);
    apb(1'b0, `PSHP_OFF_STATUS, 32'h0000_0000);
    chk("status reset", rdv & 32'h0000_301F, 32'h0000_0000);
    apb(1'b0, 12'h024, 32'h0000_0000);
    chk("unmapped err", serr, 1);
    chk("unmapped data", rdv, 32'h0000_0000);
    $display("reset and unmapped done");
    tally_and_finish;
  end
endmodule // pshp_parser_tb
`default_nettype wire
